//--- hw/eic_top.sv
// Purpose: condition four external interrupt channels for the interrupt controller
// Assumes: pin_routed and vector_irq_enable_mask come from logic on core_clk
// Notes: pin k of channel c sits at index c*PINS_PER_CH+k, lower k is the lower port number
//
// Added by the designer: strobed register access.
`timescale 1ns/1ps
`default_nettype none
module eic_top import eic_pkg::*; #(
  parameter int PINS_PER_CH = 3
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire eic_req_t bus_req,
  output logic [DW-1:0] rd_data,
  input wire logic [NCH*PINS_PER_CH-1:0] pin_state,
  input wire logic [NCH*PINS_PER_CH-1:0] pin_routed,
  input wire logic [NCH-1:0] vector_irq_enable_mask,
  output logic [NCH-1:0] channel_function,
  output logic irq_out
);
  localparam int NPIN = NCH * PINS_PER_CH;

  logic [NPIN-1:0] pin_sync;
  logic [NCH-1:0] trigger_r;
  logic [NCH-1:0] trigger_nxt;
  logic [NCH-1:0] polarity_r;
  logic [NCH-1:0] polarity_nxt;
  logic [NCH-1:0] flag_r;
  logic [NCH-1:0] flag_nxt;
  logic [NCH-1:0] mask_r;
  logic [NCH-1:0] mask_nxt;
  logic [DW-1:0] rd_data_nxt;
  logic [NCH-1:0] comb_r;
  logic [NCH-1:0] comb_nxt;
  logic [NCH-1:0] prev_r;
  logic [NCH-1:0] prev_nxt;
  logic [NCH-1:0] any_rt_r;
  logic [NCH-1:0] any_rt_nxt;
  logic [NCH-1:0] channel_function_nxt;
  logic irq_out_nxt;
  logic [NCH-1:0] level_act;
  logic [NCH-1:0] edge_ev;
  logic [NCH-1:0] pol_chg_ev;
  logic [NCH-1:0] set_ev;
  logic [NCH-1:0] clr_req;
  logic wr_trig;
  logic wr_pol;
  logic wr_flag;
  logic wr_mask;

  // pins are asynchronous; routing comes from the pin mux on this clock
  eic_sync #(
    .WIDTH(NPIN)
  ) u_sync (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .async_in(pin_state),
    .sync_out(pin_sync)
  );

  // per-channel combining of the routed pins
  for (genvar c = 0; c < NCH; c++) begin : g_ch
    logic and_v;
    logic or_v;
    logic low_v;
    logic any_v;
    always_comb begin
      and_v = 1'b1;
      or_v = 1'b0;
      low_v = 1'b0;
      any_v = 1'b0;
      // walk downwards so the lowest routed pin is the last one kept
      for (int k = PINS_PER_CH - 1; k >= 0; k--) begin
        if (pin_routed[c*PINS_PER_CH+k]) begin
          and_v = and_v & pin_sync[c*PINS_PER_CH+k];
          or_v = or_v | pin_sync[c*PINS_PER_CH+k];
          low_v = pin_sync[c*PINS_PER_CH+k];
          any_v = 1'b1;
        end
      end
      if (trigger_r[c] == TRIG_EDGE) begin
        comb_nxt[c] = low_v;
      end else if (polarity_r[c] == POL_HIGH) begin
        comb_nxt[c] = or_v;
      end else begin
        comb_nxt[c] = and_v;
      end
      any_rt_nxt[c] = any_v;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      comb_r <= '0;
      prev_r <= '0;
      any_rt_r <= '0;
    end else begin
      comb_r <= comb_nxt;
      prev_r <= prev_nxt;
      any_rt_r <= any_rt_nxt;
    end
  end

  // register decode; reserved bits 7:4 are dropped on write
  always_comb begin
    wr_trig = bus_req.wr && (bus_req.addr == ADDR_TRIGGER_SELECT);
    wr_pol = bus_req.wr && (bus_req.addr == ADDR_POLARITY_SELECT);
    wr_flag = bus_req.wr && (bus_req.addr == ADDR_IRQ_FLAG);
    wr_mask = bus_req.wr && (bus_req.addr == ADDR_IRQ_MASK);
    trigger_nxt = wr_trig ? bus_req.wdata[NCH-1:0] : trigger_r;
    polarity_nxt = wr_pol ? bus_req.wdata[NCH-1:0] : polarity_r;
    mask_nxt = wr_mask ? bus_req.wdata[NCH-1:0] : mask_r;
    clr_req = wr_flag ? bus_req.wdata[NCH-1:0] : '0;
    rd_data_nxt = RD_IDLE;
    if (bus_req.rd) begin
      case (bus_req.addr)
        ADDR_TRIGGER_SELECT: rd_data_nxt = {{(DW-NCH){1'b0}}, trigger_r};
        ADDR_POLARITY_SELECT: rd_data_nxt = {{(DW-NCH){1'b0}}, polarity_r};
        ADDR_IRQ_FLAG: rd_data_nxt = {{(DW-NCH){1'b0}}, flag_r};
        ADDR_IRQ_MASK: rd_data_nxt = {{(DW-NCH){1'b0}}, mask_r};
        default: rd_data_nxt = RD_IDLE;
      endcase
    end
  end

  // event detection and the sticky flags
  always_comb begin
    prev_nxt = comb_r;
    for (int c = 0; c < NCH; c++) begin
      // no routed pin means no event at all
      level_act[c] = any_rt_r[c] && (trigger_r[c] == TRIG_LEVEL) &&
                     (comb_r[c] == polarity_r[c]);
      edge_ev[c] = any_rt_r[c] && (trigger_r[c] == TRIG_EDGE) &&
                   (comb_r[c] != prev_r[c]) && (comb_r[c] == polarity_r[c]);
      // a flipped polarity on a pin already at the new active level counts as an edge
      pol_chg_ev[c] = wr_pol && any_rt_r[c] && (trigger_r[c] == TRIG_EDGE) &&
                      (bus_req.wdata[c] != polarity_r[c]) &&
                      (comb_r[c] == bus_req.wdata[c]);
    end
    set_ev = level_act | edge_ev | pol_chg_ev;
    // set wins over a clear in the same cycle
    flag_nxt = (flag_r & ~clr_req) | set_ev;
    channel_function_nxt = flag_nxt & vector_irq_enable_mask;
    irq_out_nxt = |(flag_nxt & mask_r & vector_irq_enable_mask);
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      trigger_r <= RST_TRIGGER_SELECT;
      polarity_r <= RST_POLARITY_SELECT;
      flag_r <= RST_IRQ_FLAG;
      mask_r <= RST_IRQ_MASK;
      rd_data <= RD_IDLE;
      channel_function <= '0;
      irq_out <= 1'b0;
    end else begin
      trigger_r <= trigger_nxt;
      polarity_r <= polarity_nxt;
      flag_r <= flag_nxt;
      mask_r <= mask_nxt;
      rd_data <= rd_data_nxt;
      channel_function <= channel_function_nxt;
      irq_out <= irq_out_nxt;
    end
  end

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_n);

  property p_trig_write;
    (bus_req.wr && bus_req.addr == ADDR_TRIGGER_SELECT) |=> trigger_r == $past(bus_req.wdata[NCH-1:0]);
  endproperty
  a_trig_write: assert property (p_trig_write) else $error("trigger select not updated");

  property p_pol_read;
    (bus_req.rd && bus_req.addr == ADDR_POLARITY_SELECT) |=> rd_data == {{(DW-NCH){1'b0}}, $past(polarity_r)};
  endproperty
  a_pol_read: assert property (p_pol_read) else $error("polarity readback wrong");

  property p_level_set;
    (trigger_r[0] == TRIG_LEVEL && any_rt_r[0] && comb_r[0] == polarity_r[0]) |=> flag_r[0];
  endproperty
  a_level_set: assert property (p_level_set) else $error("level active did not set flag");

  property p_and_low;
    (trigger_r[0] == TRIG_LEVEL && polarity_r[0] == POL_LOW) |=>
      comb_r[0] == $past(&(pin_sync[PINS_PER_CH-1:0] | ~pin_routed[PINS_PER_CH-1:0]));
  endproperty
  a_and_low: assert property (p_and_low) else $error("low level not an AND of pins");

  property p_or_high;
    (trigger_r[1] == TRIG_LEVEL && polarity_r[1] == POL_HIGH) |=>
      comb_r[1] == $past(|(pin_sync[2*PINS_PER_CH-1:PINS_PER_CH] & pin_routed[2*PINS_PER_CH-1:PINS_PER_CH]));
  endproperty
  a_or_high: assert property (p_or_high) else $error("high level not an OR of pins");

  property p_edge_lowest;
    (trigger_r[2] == TRIG_EDGE && pin_routed[2*PINS_PER_CH]) |=> comb_r[2] == $past(pin_sync[2*PINS_PER_CH]);
  endproperty
  a_edge_lowest: assert property (p_edge_lowest) else $error("edge mode not on lowest pin");

  property p_edge_sticky;
    (any_rt_r[2] && trigger_r[2] == TRIG_EDGE && polarity_r[2] == POL_HIGH && comb_r[2] && !prev_r[2])
      |=> flag_r[2] ##1 (flag_r[2] || $past(clr_req[2]));
  endproperty
  a_edge_sticky: assert property (p_edge_sticky) else $error("rising edge flag lost");

  property p_flag_clear;
    (clr_req[0] && !set_ev[0]) |=> !flag_r[0];
  endproperty
  a_flag_clear: assert property (p_flag_clear) else $error("write one did not clear flag");

  property p_gated;
    channel_function[0] |-> $past(vector_irq_enable_mask[0]) && ($past(flag_r[0]) || $past(set_ev[0]));
  endproperty
  a_gated: assert property (p_gated) else $error("channel raised while disabled");

  property p_unrouted;
    (!any_rt_r[2] && !pol_chg_ev[2] && !flag_r[2]) |=> !flag_r[2];
  endproperty
  a_unrouted: assert property (p_unrouted) else $error("unrouted channel set flag");

  c_edge_fall: cover property (any_rt_r[2] && trigger_r[2] == TRIG_EDGE && !comb_r[2] && prev_r[2]);
  c_set_clear_same: cover property (clr_req[0] && set_ev[0]);
  c_irq: cover property (!irq_out ##1 irq_out);
  c_pol_change: cover property (pol_chg_ev != '0);
endmodule : eic_top
`default_nettype wire

//--- hw/eic_pkg.sv
// Purpose: shared constants and types for the external interrupt conditioner
// Assumes: four channels, 32-bit register port, byte addresses as printed
// Notes on behaviour
// - trigger bit zero level, one edge
// - polarity zero low/falling, one high/rising
// - interrupt needs routed pin and enable
// - polarity change may set flag; write-one clears
// - take every pin state plus routing indication
// - low-active level: AND of routed pins
// - high-active level: OR of routed pins
// - edge mode uses lowest-numbered routed pin
// - bit n of trigger register governs channel n
package eic_pkg;
  localparam int NCH = 4;
  localparam int DW = 32;
  localparam int AW = 32;
  localparam int REG_W = 8;

  localparam logic [AW-1:0] ADDR_TRIGGER_SELECT = 32'hE01FC148;
  localparam logic [AW-1:0] ADDR_POLARITY_SELECT = 32'hE01FC14C;
  localparam logic [AW-1:0] ADDR_IRQ_FLAG = 32'hE01FC150;
  localparam logic [AW-1:0] ADDR_IRQ_MASK = 32'hE01FC154;

  localparam logic [NCH-1:0] RST_TRIGGER_SELECT = 4'h0;
  localparam logic [NCH-1:0] RST_POLARITY_SELECT = 4'h0;
  localparam logic [NCH-1:0] RST_IRQ_FLAG = 4'h0;
  localparam logic [NCH-1:0] RST_IRQ_MASK = 4'h0;
  localparam logic [DW-1:0] RD_IDLE = 32'h00000000;

  localparam logic TRIG_LEVEL = 1'b0;
  localparam logic TRIG_EDGE = 1'b1;
  localparam logic POL_LOW = 1'b0;
  localparam logic POL_HIGH = 1'b1;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [AW-1:0] addr;
    logic [DW-1:0] wdata;
  } eic_req_t;
endpackage : eic_pkg

//--- hw/eic_sync.sv
// Purpose: two-flop synchroniser for the raw pin levels
// Assumes: inputs asynchronous to core_clk
// Notes: first stage feeds only the second stage
`timescale 1ns/1ps
`default_nettype none
module eic_sync import eic_pkg::*; #(
  parameter int WIDTH = 12
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta_r;
  logic [WIDTH-1:0] meta_nxt;
  logic [WIDTH-1:0] sync_nxt;

  always_comb begin
    meta_nxt = async_in;
    sync_nxt = meta_r;
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_r <= '0;
      sync_out <= '0;
    end else begin
      meta_r <= meta_nxt;
      sync_out <= sync_nxt;
    end
  end
endmodule : eic_sync
`default_nettype wire

//--- test/eic_far_model.sv
// Purpose: outside pins and interrupt controller enables
// Assumes: bench sets wanted pin levels and enables
// Notes: levels move at the clock edge, so sync latency is fixed
`timescale 1ns/1ps
`default_nettype none
module eic_far_model import eic_pkg::*; (
  input wire logic core_clk,
  input wire logic [11:0] lvl,
  input wire logic [NCH-1:0] en,
  output logic [11:0] pin_state,
  output logic [NCH-1:0] vector_irq_enable_mask
);
  always @(posedge core_clk) begin
    pin_state <= lvl;
    vector_irq_enable_mask <= en;
  end
endmodule : eic_far_model
`default_nettype wire

//--- test/tb_eic_top.sv
// Purpose: self-checking bench for the interrupt conditioner
// Assumes: three pins per channel, pin k of channel c at c*3+k
// Notes: reserved bits always written as zero
`timescale 1ns/1ps
`default_nettype none
module tb_eic_top import eic_pkg::*; ;
  localparam logic [AW-1:0] TR = ADDR_TRIGGER_SELECT;
  localparam logic [AW-1:0] PO = ADDR_POLARITY_SELECT;
  localparam logic [AW-1:0] FL = ADDR_IRQ_FLAG;
  localparam logic [AW-1:0] MK = ADDR_IRQ_MASK;
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  eic_req_t req = '0;
  logic [DW-1:0] rd_data;
  logic [11:0] lvl = 12'hFFF;
  logic [11:0] routed = 12'h000;
  logic [NCH-1:0] en = 4'h0;
  logic [11:0] pins;
  logic [NCH-1:0] vmask;
  logic [NCH-1:0] cf;
  logic irq;
  int n_errors = 0;
  int tests_run = 0;
  initial forever #50 core_clk = ~core_clk;
  eic_far_model far (.core_clk(core_clk), .lvl(lvl), .en(en), .pin_state(pins),
    .vector_irq_enable_mask(vmask));
  eic_top #(.PINS_PER_CH(3)) dut (.core_clk(core_clk), .rst_n(rst_n), .bus_req(req),
    .rd_data(rd_data), .pin_state(pins), .pin_routed(routed),
    .vector_irq_enable_mask(vmask), .channel_function(cf), .irq_out(irq));
  task automatic chk(input logic [DW-1:0] got, input logic [DW-1:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected at %0t: read %h want %h", $time, got, exp);
    end
  endtask : chk
  task automatic chk_out(input logic i, input logic [NCH-1:0] c);
    tests_run++;
    if (irq !== i || cf !== c) begin
      n_errors++;
      $display("unexpected at %0t: irq %b cf %b", $time, irq, cf);
    end
  endtask : chk_out
  task automatic wr(input logic [AW-1:0] a, input logic [DW-1:0] d);
    @(posedge core_clk);
    req <= '{1'b1, 1'b0, a, d};
    @(posedge core_clk);
    req <= '0;
  endtask : wr
  task automatic rd(input logic [AW-1:0] a, input logic [DW-1:0] exp);
    @(posedge core_clk);
    req <= '{1'b0, 1'b1, a, 32'h0};
    @(posedge core_clk);
    req <= '0;
    #1 chk(rd_data, exp);
  endtask : rd
  // model stage plus sync plus flag: eight edges leave margin
  task automatic settle;
    repeat (8) @(posedge core_clk);
  endtask : settle
  task automatic pin(input int i, input logic v);
    @(posedge core_clk);
    lvl[i] <= v;
    settle();
  endtask : pin
  task automatic t_reset;
    rd(TR, 32'h0);
    rd(PO, 32'h0);
    rd(FL, 32'h0);
    rd(MK, 32'h0);
    rd(MK + 32'h4, 32'h0);
    @(posedge core_clk);
    #1 chk(rd_data, 32'h0);
    chk_out(1'b0, 4'h0);
    $display("t_reset done");
  endtask : t_reset
  task automatic t_and;
    @(posedge core_clk);
    routed[1:0] <= 2'b11;
    lvl[2] <= 1'b0;
    wr(MK, 32'h1);
    settle();
    wr(FL, 32'h1);
    en <= 4'h1;
    rd(FL, 32'h0);
    pin(0, 1'b0);
    rd(FL, 32'h1);
    chk_out(1'b1, 4'h1);
    // clear while the level is still active: the set must win
    wr(FL, 32'h1);
    rd(FL, 32'h1);
    wr(MK, 32'h0);
    @(posedge core_clk);
    #1 chk_out(1'b0, 4'h1);
    wr(MK, 32'h1);
    @(posedge core_clk);
    en <= 4'h0;
    settle();
    #1 chk_out(1'b0, 4'h0);
    pin(0, 1'b1);
    wr(FL, 32'h1);
    rd(FL, 32'h0);
    $display("t_and done");
  endtask : t_and
  task automatic t_or;
    @(posedge core_clk);
    lvl[4:3] <= 2'b00;
    routed[4:3] <= 2'b11;
    wr(PO, 32'h2);
    settle();
    wr(FL, 32'h2);
    rd(FL, 32'h0);
    pin(3, 1'b1);
    rd(FL, 32'h2);
    pin(3, 1'b0);
    wr(FL, 32'h2);
    rd(FL, 32'h0);
    $display("t_or done");
  endtask : t_or
  task automatic t_edge;
    @(posedge core_clk);
    lvl[7:6] <= 2'b00;
    routed[7:6] <= 2'b11;
    wr(TR, 32'h4);
    wr(PO, 32'h6);
    settle();
    wr(FL, 32'h4);
    rd(TR, 32'h4);
    rd(FL, 32'h0);
    pin(7, 1'b1);
    rd(FL, 32'h0);
    pin(6, 1'b1);
    pin(6, 1'b0);
    rd(FL, 32'h4);
    wr(FL, 32'h4);
    rd(FL, 32'h0);
    // signal already low, so falling polarity flags at once
    wr(PO, 32'h2);
    settle();
    rd(FL, 32'h4);
    wr(FL, 32'h4);
    pin(6, 1'b1);
    rd(FL, 32'h0);
    pin(6, 1'b0);
    rd(FL, 32'h4);
    $display("t_edge done");
  endtask : t_edge
  task automatic final_report;
    $display("checks %0d mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : final_report
  initial begin
    repeat (2) @(posedge core_clk);
    rst_n <= 1'b1;
    t_reset();
    t_and();
    t_or();
    t_edge();
    final_report();
  end
endmodule : tb_eic_top
`default_nettype wire
